/* File: shared/omp_pkg.sv */
// Constants and types of the oscillator monitor and power manager
// Functional notes
// - Oscillator edges are watched by ticks of a PLL clock independent of crystal input.
// - Missing oscillator edges raise the monitor interrupt and move CPU onto PLL clock.
// - Fallback in direct drive feeds the PLL base clock undivided to the CPU.
// - Fallback in prescaler mode halves the PLL base clock for the CPU.
// - Only a hardware reset returns the CPU from the PLL fallback to the oscillator.
// - With monitor disabled and no fallback the PLL idles; CPU runs from oscillator, prescaler or divider.
// - With monitor disabled a stopped oscillator raises no interrupt.
// - Monitor disable is loaded with the inverted read strobe pin after reset.
// - Idle stops the CPU clock while peripheral clocks keep running.
// - Power down stops all clocks; the real-time clock may optionally keep running.
// - Slow down divides the oscillator by 1 to 32, halved again with prescaler.
// - Software may switch the PLL off while in slow down mode.
// - Each peripheral can be disabled and enabled on its own by software.
// - One group bit disables a fixed large subset of peripherals at once.
// - Real-time clock wake events end sleep phases for full speed operation.
// - Power down is taken only while the non-maskable interrupt pin is low.
package omp_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [4:0] OFF_SYSCFG = 5'h00;
  localparam logic [4:0] OFF_CLKCFG = 5'h04;
  localparam logic [4:0] OFF_PERDIS = 5'h08;
  localparam logic [4:0] OFF_STATUS = 5'h0c;
  localparam logic [4:0] OFF_MASK   = 5'h10;
  localparam logic [4:0] OFF_STATE  = 5'h14;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SYS_MON_DIS  = 0;
  localparam int SYS_RTC_KEEP = 1;
  localparam int CLK_SD_EN    = 0;
  localparam int CLK_PLL_OFF  = 1;
  localparam int CLK_PRESC    = 2;
  localparam int CLK_DIV_LSB  = 4;
  localparam int PER_GROUP    = 16;
  localparam int ST_MON_FAIL  = 0;
  localparam int ST_RTC_WAKE  = 1;
  localparam int NUM_PERIPH   = 16;
  localparam int NUM_EVT      = 2;
  localparam int PER_W        = 7;
  localparam logic [15:0] GROUP_MASK = 16'h0ffe;
  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [4:0] DIV_RST    = 5'h00;
  localparam logic [1:0] MASK_RST   = 2'h0;
  localparam int         MISS_LIMIT = 4;
  localparam int         MISS_W     = 4;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {MODE_RUN, MODE_IDLE, MODE_PDOWN} omp_mode_t;
  typedef struct packed {
    logic                  strap_done;
    logic                  mon_dis;
    logic                  rtc_keep;
    logic                  sd_en;
    logic                  pll_off;
    logic                  presc;
    logic [4:0]            sd_div;
    logic [NUM_PERIPH-1:0] per_dis;
    logic                  grp_dis;
    logic [NUM_EVT-1:0]    status;
    logic [NUM_EVT-1:0]    mask;
    logic                  fallback;
    logic [MISS_W-1:0]     miss_cnt;
    logic                  osc_q;
    logic [PER_W-1:0]      ph_cnt;
    logic [PER_W-1:0]      period;
    logic                  src_pll;
    logic                  cpu_en;
    logic                  per_tick;
    omp_mode_t             mode;
    logic                  ack;
    logic [31:0]           rdata;
  } omp_state_t;
  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [31:0] writedata;
  } omp_avm_req_t;
endpackage

/* File: src/omp_manager.sv */
// Oscillator monitor, clock source selection and power management
//
// The Avalon-MM register port and the register addresses were left to the implementer.
module omp_manager #(
  parameter int MISS_LIMIT = omp_pkg::MISS_LIMIT
) (
  input  wire logic                          i_sys_clk,
  input  wire logic                          i_rst_n,
  input  wire logic                          i_clk_en,
  input  wire omp_pkg::omp_avm_req_t         i_avm,
  output logic                               o_avm_waitrequest,
  output logic [31:0]                        o_avm_readdata,
  input  wire logic                          i_osc_clk,
  input  wire logic                          i_pll_tick,
  input  wire logic                          i_rd_n,
  input  wire logic                          i_nmi_n,
  input  wire logic                          i_idle_req,
  input  wire logic                          i_power_down_instr_req,
  input  wire logic                          i_wake_irq,
  input  wire logic                          i_rtc_wake,
  output logic                               o_cpu_clk_en,
  output logic                               o_periph_tick,
  output logic [omp_pkg::NUM_PERIPH-1:0]     o_periph_en,
  output logic                               o_pll_run,
  output logic                               o_rtc_run,
  output logic                               o_fallback,
  output logic                               o_irq
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  omp_pkg::omp_state_t s_reg;
  omp_pkg::omp_state_t s_next;
  logic                osc_rise;
  logic                pll_run;
  logic                mon_act;
  logic                src_tick;
  logic                pulse;
  logic                tgt_src;
  logic [omp_pkg::PER_W-1:0] tgt_period;
  logic [omp_pkg::PER_W-1:0] base_div;
  logic                wr;
  logic                rd;
  logic [omp_pkg::NUM_EVT-1:0] evt;
  logic [omp_pkg::NUM_EVT-1:0] w1c;

  localparam logic [omp_pkg::MISS_W-1:0] MISS_LAST =
    omp_pkg::MISS_W'(MISS_LIMIT - 1);

  assign osc_rise = i_osc_clk & ~s_reg.osc_q;
  assign pll_run  = s_reg.mode != omp_pkg::MODE_PDOWN &&
                    (s_reg.fallback || (!s_reg.mon_dis &&
                     !(s_reg.sd_en && s_reg.pll_off)));
  assign mon_act  = pll_run && !s_reg.mon_dis && !s_reg.fallback &&
                    s_reg.strap_done;
  assign src_tick = s_reg.src_pll ? i_pll_tick : osc_rise;
  assign pulse    = src_tick && (s_reg.ph_cnt >= s_reg.period - 7'h01);
  assign wr       = i_avm.write && !s_reg.ack;
  assign rd       = i_avm.read && !s_reg.ack;

  // ----------------------------------------------------------------
  // Target clock source and divide
  // ----------------------------------------------------------------
  always_comb begin
    base_div = s_reg.sd_en && !s_reg.fallback ?
               {2'h0, s_reg.sd_div} + 7'h01 : 7'h01;
    tgt_period = s_reg.presc ? {base_div[5:0], 1'b0} : base_div;
    tgt_src    = s_reg.fallback;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next       = s_reg;
    evt          = '0;
    w1c          = '0;
    s_next.osc_q = i_osc_clk;
    s_next.ack   = (i_avm.read || i_avm.write) && !s_reg.ack;
    // Oscillator supervision by PLL ticks
    if (mon_act) begin
      if (osc_rise) begin
        s_next.miss_cnt = '0;
      end else if (i_pll_tick) begin
        if (s_reg.miss_cnt == MISS_LAST) begin
          s_next.fallback = 1'b1;
          evt[omp_pkg::ST_MON_FAIL] = 1'b1;
        end else begin
          s_next.miss_cnt = s_reg.miss_cnt + 4'h1;
        end
      end
    end
    // Clock phase generation, source swapped at phase end, or at once on fallback
    s_next.cpu_en   = 1'b0;
    s_next.per_tick = 1'b0;
    if (src_tick) begin
      if (pulse) begin
        s_next.ph_cnt  = '0;
        s_next.period  = tgt_period;
        s_next.src_pll = tgt_src;
      end else begin
        s_next.ph_cnt = s_reg.ph_cnt + 7'h01;
      end
    end
    if (s_next.fallback && !s_reg.src_pll) begin
      s_next.src_pll = 1'b1;
      s_next.ph_cnt  = '0;
      s_next.period  = s_reg.presc ? 7'h02 : 7'h01;
    end
    s_next.cpu_en   = pulse && s_reg.mode == omp_pkg::MODE_RUN;
    s_next.per_tick = pulse && s_reg.mode != omp_pkg::MODE_PDOWN;
    // Power saving modes
    unique case (s_reg.mode)
      omp_pkg::MODE_RUN: begin
        if (i_power_down_instr_req && !i_nmi_n) begin
          s_next.mode = omp_pkg::MODE_PDOWN;
        end else if (i_idle_req) begin
          s_next.mode = omp_pkg::MODE_IDLE;
        end
      end
      omp_pkg::MODE_IDLE: begin
        if (i_wake_irq || i_rtc_wake) begin
          s_next.mode = omp_pkg::MODE_RUN;
        end
      end
      omp_pkg::MODE_PDOWN: begin
        if (s_reg.rtc_keep && i_rtc_wake) begin
          s_next.mode = omp_pkg::MODE_RUN;
        end
      end
      default: s_next.mode = omp_pkg::MODE_RUN;
    endcase
    if (i_rtc_wake && (s_reg.mode != omp_pkg::MODE_PDOWN || s_reg.rtc_keep)) begin
      evt[omp_pkg::ST_RTC_WAKE] = 1'b1;
    end
    // Register writes
    if (wr) begin
      unique case (i_avm.address)
        omp_pkg::OFF_SYSCFG: begin
          s_next.mon_dis  = i_avm.writedata[omp_pkg::SYS_MON_DIS];
          s_next.rtc_keep = i_avm.writedata[omp_pkg::SYS_RTC_KEEP];
        end
        omp_pkg::OFF_CLKCFG: begin
          s_next.sd_en   = i_avm.writedata[omp_pkg::CLK_SD_EN];
          s_next.pll_off = i_avm.writedata[omp_pkg::CLK_PLL_OFF];
          s_next.presc   = i_avm.writedata[omp_pkg::CLK_PRESC];
          s_next.sd_div  = i_avm.writedata[omp_pkg::CLK_DIV_LSB +: 5];
        end
        omp_pkg::OFF_PERDIS: begin
          s_next.per_dis = i_avm.writedata[omp_pkg::NUM_PERIPH-1:0];
          s_next.grp_dis = i_avm.writedata[omp_pkg::PER_GROUP];
        end
        omp_pkg::OFF_STATUS: w1c = i_avm.writedata[omp_pkg::NUM_EVT-1:0];
        omp_pkg::OFF_MASK:   s_next.mask = i_avm.writedata[omp_pkg::NUM_EVT-1:0];
        default: ;
      endcase
    end
    s_next.status = (s_reg.status & ~w1c) | evt;
    // Strap capture on the first enabled edge after reset
    if (!s_reg.strap_done) begin
      s_next.strap_done = 1'b1;
      s_next.mon_dis    = ~i_rd_n;
    end
    // Register reads
    if (rd) begin
      s_next.rdata = '0;
      unique case (i_avm.address)
        omp_pkg::OFF_SYSCFG: begin
          s_next.rdata[omp_pkg::SYS_MON_DIS]  = s_reg.mon_dis;
          s_next.rdata[omp_pkg::SYS_RTC_KEEP] = s_reg.rtc_keep;
        end
        omp_pkg::OFF_CLKCFG: begin
          s_next.rdata[omp_pkg::CLK_SD_EN]          = s_reg.sd_en;
          s_next.rdata[omp_pkg::CLK_PLL_OFF]        = s_reg.pll_off;
          s_next.rdata[omp_pkg::CLK_PRESC]          = s_reg.presc;
          s_next.rdata[omp_pkg::CLK_DIV_LSB +: 5]   = s_reg.sd_div;
        end
        omp_pkg::OFF_PERDIS: begin
          s_next.rdata[omp_pkg::NUM_PERIPH-1:0] = s_reg.per_dis;
          s_next.rdata[omp_pkg::PER_GROUP]      = s_reg.grp_dis;
        end
        omp_pkg::OFF_STATUS: s_next.rdata[omp_pkg::NUM_EVT-1:0] = s_reg.status;
        omp_pkg::OFF_MASK:   s_next.rdata[omp_pkg::NUM_EVT-1:0] = s_reg.mask;
        omp_pkg::OFF_STATE:  s_next.rdata[4:0] = {s_reg.mode, s_reg.src_pll,
                                                   s_reg.fallback, pll_run};
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers; only reset leaves the fallback
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_reg          <= '0;
      s_reg.sd_div   <= omp_pkg::DIV_RST;
      s_reg.mask     <= omp_pkg::MASK_RST;
      s_reg.period   <= 7'h01;
      s_reg.mode     <= omp_pkg::MODE_RUN;
    end else if (i_clk_en) begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_avm_waitrequest = (i_avm.read || i_avm.write) && !s_reg.ack;
  assign o_avm_readdata    = s_reg.rdata;
  assign o_cpu_clk_en      = s_reg.cpu_en;
  assign o_periph_tick     = s_reg.per_tick;
  assign o_pll_run         = pll_run;
  assign o_rtc_run         = s_reg.mode != omp_pkg::MODE_PDOWN || s_reg.rtc_keep;
  assign o_fallback        = s_reg.fallback;
  assign o_irq             = |(s_reg.status & s_reg.mask);

  for (genvar g = 0; g < omp_pkg::NUM_PERIPH; g++) begin : g_per
    assign o_periph_en[g] = !s_reg.per_dis[g] &&
                            !(s_reg.grp_dis && omp_pkg::GROUP_MASK[g]) &&
                            s_reg.mode != omp_pkg::MODE_PDOWN;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  property p_fail_detect;
    i_clk_en && mon_act && !osc_rise && i_pll_tick && s_reg.miss_cnt == MISS_LAST
      |=> s_reg.fallback && s_reg.status[omp_pkg::ST_MON_FAIL] && s_reg.src_pll;
  endproperty
  a_fail_detect: assert property (p_fail_detect) else $error("missed edges not caught");

  property p_edge_clears;
    i_clk_en && mon_act && osc_rise |=> s_reg.miss_cnt == '0;
  endproperty
  a_edge_clears: assert property (p_edge_clears) else $error("edge did not clear count");

  property p_fb_sticky;
    s_reg.fallback |=> s_reg.fallback && s_reg.src_pll;
  endproperty
  a_fb_sticky: assert property (p_fb_sticky) else $error("fallback left without reset");

  property p_fb_direct;
    i_clk_en && s_reg.fallback && s_reg.src_pll && pulse && !s_reg.presc
      |=> s_reg.period == 7'h01;
  endproperty
  a_fb_direct: assert property (p_fb_direct) else $error("direct fallback divided");

  property p_fb_presc;
    i_clk_en && s_reg.fallback && s_reg.src_pll && pulse && s_reg.presc
      |=> s_reg.period == 7'h02;
  endproperty
  a_fb_presc: assert property (p_fb_presc) else $error("prescaler fallback not halved");

  property p_dis_pll_idle;
    s_reg.mon_dis && !s_reg.fallback |-> !o_pll_run;
  endproperty
  a_dis_pll_idle: assert property (p_dis_pll_idle) else $error("PLL runs while disabled");

  property p_dis_no_irq;
    s_reg.mon_dis && !s_reg.status[omp_pkg::ST_MON_FAIL]
      |=> !s_reg.status[omp_pkg::ST_MON_FAIL];
  endproperty
  a_dis_no_irq: assert property (p_dis_no_irq) else $error("request while disabled");

  property p_strap;
    !s_reg.strap_done && i_clk_en |=> s_reg.mon_dis == !$past(i_rd_n);
  endproperty
  a_strap: assert property (p_strap) else $error("strap not loaded");

  property p_idle_stop;
    s_reg.mode == omp_pkg::MODE_IDLE |=> !o_cpu_clk_en;
  endproperty
  a_idle_stop: assert property (p_idle_stop) else $error("CPU clocked in idle");

  property p_pdown_stop;
    s_reg.mode == omp_pkg::MODE_PDOWN |=> !o_cpu_clk_en && !o_periph_tick;
  endproperty
  a_pdown_stop: assert property (p_pdown_stop) else $error("clock in power down");

  property p_slowdown;
    i_clk_en && pulse && !s_reg.fallback && s_reg.sd_en && !s_reg.presc
      |=> s_reg.period == {2'h0, $past(s_reg.sd_div)} + 7'h01;
  endproperty
  a_slowdown: assert property (p_slowdown) else $error("slow down factor wrong");

  property p_nmi_gate;
    s_reg.mode == omp_pkg::MODE_RUN && i_nmi_n |=> s_reg.mode != omp_pkg::MODE_PDOWN;
  endproperty
  a_nmi_gate: assert property (p_nmi_gate) else $error("power down without NMI low");

  property p_phase_hold;
    i_clk_en && !pulse && !s_next.fallback |=> s_reg.period == $past(s_reg.period);
  endproperty
  a_phase_hold: assert property (p_phase_hold) else $error("source changed mid phase");

  c_fallback: cover property ($rose(s_reg.fallback));
  c_pdown:    cover property (s_reg.mode == omp_pkg::MODE_PDOWN ##[1:50] s_reg.mode == omp_pkg::MODE_RUN);
  c_idle:     cover property (s_reg.mode == omp_pkg::MODE_IDLE ##1 s_reg.mode == omp_pkg::MODE_RUN);
endmodule

/* File: verification/omp_xtal_model.sv */
// Crystal oscillator, PLL base clock and read strobe strap model
module omp_xtal_model #(
  parameter int OSC_HALF = 2,
  parameter int PLL_DIV  = 3
) (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  input  wire logic i_osc_stop,
  input  wire logic i_strap_low,
  input  wire logic i_pll_run,
  output logic      o_osc_clk,
  output logic      o_pll_tick,
  output logic      o_rd_n
);
  timeunit 1ns;
  timeprecision 1ns;
  int osc_cnt;
  int pll_cnt;
  int hold_cnt;
  initial begin
    o_osc_clk = 1'b0;
    o_pll_tick = 1'b0;
    o_rd_n = 1'b1;
    osc_cnt = 0;
    pll_cnt = 0;
    hold_cnt = 0;
  end
  // ----------------------------------------------------------------
  // Oscillator, stops dead when told to
  // ----------------------------------------------------------------
  always @(posedge i_sys_clk) begin
    if (!i_osc_stop) begin
      osc_cnt <= (osc_cnt == OSC_HALF - 1) ? 0 : osc_cnt + 1;
      if (osc_cnt == OSC_HALF - 1) o_osc_clk <= ~o_osc_clk;
    end
  end
  // ----------------------------------------------------------------
  // PLL base clock, own counter, silent while idle
  // ----------------------------------------------------------------
  always @(posedge i_sys_clk) begin
    pll_cnt <= (pll_cnt == PLL_DIV - 1) ? 0 : pll_cnt + 1;
    o_pll_tick <= i_pll_run && (pll_cnt == PLL_DIV - 1);
  end
  // ----------------------------------------------------------------
  // Strap level held through reset, pulled high afterwards
  // ----------------------------------------------------------------
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hold_cnt <= 0;
      o_rd_n <= ~i_strap_low;
    end else if (hold_cnt < 4) begin
      hold_cnt <= hold_cnt + 1;
    end else begin
      o_rd_n <= 1'b1;
    end
  end
endmodule

/* File: verification/osc_monitor_power_manager_test.sv */
// Self-checking bench of the oscillator monitor and power manager
module osc_monitor_power_manager_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PLL_DIV = 3;
  logic sys_clk, i_rst_n, i_nmi_n, i_idle_req, i_power_down_instr_req, i_wake_irq, i_rtc_wake;
  logic osc_clk, pll_tick, rd_n, osc_stop, strap_low, waitreq;
  logic cpu_en, ptick, pll_run, rtc_run, fallback, irq;
  logic [31:0] rdata;
  logic [31:0] q;
  logic [15:0] per_en;
  omp_pkg::omp_avm_req_t avm;
  int failures, comparisons, cycles, p, nc, np;
  omp_manager #(.MISS_LIMIT(3)) omp_manager_inst (.i_sys_clk(sys_clk), .i_rst_n(i_rst_n),
    .i_clk_en(1'b1), .i_avm(avm), .o_avm_waitrequest(waitreq), .o_avm_readdata(rdata),
    .i_osc_clk(osc_clk), .i_pll_tick(pll_tick), .i_rd_n(rd_n), .i_nmi_n(i_nmi_n),
    .i_idle_req(i_idle_req), .i_power_down_instr_req(i_power_down_instr_req), .i_wake_irq(i_wake_irq),
    .i_rtc_wake(i_rtc_wake), .o_cpu_clk_en(cpu_en), .o_periph_tick(ptick),
    .o_periph_en(per_en), .o_pll_run(pll_run), .o_rtc_run(rtc_run), .o_fallback(fallback),
    .o_irq(irq));
  omp_xtal_model #(.OSC_HALF(2), .PLL_DIV(PLL_DIV)) omp_xtal_model_inst (.i_sys_clk(sys_clk),
    .i_rst_n(i_rst_n), .i_osc_stop(osc_stop), .i_strap_low(strap_low), .i_pll_run(pll_run),
    .o_osc_clk(osc_clk), .o_pll_tick(pll_tick), .o_rd_n(rd_n));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failures++;
      conclude();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    avm <= '{read: ~wr, write: wr, address: a, writedata: d};
    do begin
      @(posedge sys_clk);
      n++;
    end while (waitreq !== 1'b0 && n < 100);
    q = rdata;
    avm <= '0;
    if (n >= 100) check("waitrequest", waitreq, 32'h0);
  endtask
  task automatic do_reset(input logic s);
    strap_low <= s;
    i_rst_n <= 1'b0;
    repeat (12) @(posedge sys_clk);
    i_rst_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
  endtask
  // One-cycle request: 0 idle, 1 wake interrupt, 2 power down, 3 RTC wake
  task automatic pulse(input int w);
    @(posedge sys_clk);
    case (w)
      0: i_idle_req <= 1'b1;
      1: i_wake_irq <= 1'b1;
      2: i_power_down_instr_req <= 1'b1;
      default: i_rtc_wake <= 1'b1;
    endcase
    @(posedge sys_clk);
    i_idle_req <= 1'b0;
    i_wake_irq <= 1'b0;
    i_power_down_instr_req <= 1'b0;
    i_rtc_wake <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  // Interval between the last two of three CPU clock pulses
  task automatic period();
    int k, t;
    p = 0;
    for (k = 0; k < 3; k++) begin
      t = 0;
      do begin
        @(negedge sys_clk);
        t++;
      end while (cpu_en !== 1'b1 && t < 1000);
      p = t;
    end
  endtask
  task automatic count(input int n);
    nc = 0;
    np = 0;
    repeat (n) begin
      @(negedge sys_clk);
      if (cpu_en === 1'b1) nc++;
      if (ptick === 1'b1) np++;
    end
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  logic [31:0] cfg [5] = '{32'h0, 32'h4, 32'h1f1, 32'h1f5, 32'h35};
  int exp_p [5] = '{4, 8, 128, 256, 32};
  initial begin
    i_rst_n = 1'b0;
    avm = '0;
    i_nmi_n = 1'b1;
    i_idle_req = 1'b0;
    i_power_down_instr_req = 1'b0;
    i_wake_irq = 1'b0;
    i_rtc_wake = 1'b0;
    osc_stop = 1'b0;
    strap_low = 1'b0;
    failures = 0;
    comparisons = 0;
    cycles = 0;
    do_reset(1'b0);
    bus(1'b0, omp_pkg::OFF_SYSCFG, 32'h0); check("mon_dis", q, 32'h0);
    bus(1'b0, omp_pkg::OFF_STATE, 32'h0); check("state", q & 32'h7, 32'h1);
    bus(1'b0, 5'h1c, 32'h0); check("unmapped", q, 32'h0);
    bus(1'b1, omp_pkg::OFF_PERDIS, 32'h1); check("per_en", per_en, 32'hfffe);
    bus(1'b1, omp_pkg::OFF_PERDIS, 32'h10000);
    check("per_grp", per_en, {16'h0, ~omp_pkg::GROUP_MASK});
    bus(1'b1, omp_pkg::OFF_PERDIS, 32'h0); check("per_all", per_en, 32'hffff);
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, omp_pkg::OFF_CLKCFG, cfg[i]);
      period(); check("cpu_period", p, exp_p[i]);
    end
    bus(1'b1, omp_pkg::OFF_CLKCFG, 32'h3); check("pll_off", pll_run, 32'h0);
    bus(1'b1, omp_pkg::OFF_CLKCFG, 32'h0); check("pll_on", pll_run, 32'h1);
    pulse(0); count(64); check("idle_cpu", nc, 0);
    check("idle_per", np > 0, 32'h1);
    pulse(1); count(32); check("wake_cpu", nc > 0, 32'h1);
    pulse(2); count(32); check("pd_refused", nc > 0, 32'h1);
    bus(1'b1, omp_pkg::OFF_SYSCFG, 32'h2);
    bus(1'b1, omp_pkg::OFF_MASK, 32'h2);
    i_nmi_n <= 1'b0;
    pulse(2); count(64); check("pd_clocks", nc + np, 0);
    check("pd_rtc", rtc_run, 32'h1);
    pulse(3); count(32); check("rtc_wake", nc > 0, 32'h1);
    i_nmi_n <= 1'b1;
    bus(1'b0, omp_pkg::OFF_STATUS, 32'h0); check("st_wake", q & 32'h3, 32'h2);
    check("irq_wake", irq, 32'h1);
    bus(1'b1, omp_pkg::OFF_STATUS, 32'h2); check("irq_clr", irq, 32'h0);
    bus(1'b1, omp_pkg::OFF_MASK, 32'h1);
    osc_stop <= 1'b1;
    for (int t = 0; t < 200 && fallback !== 1'b1; t++) @(negedge sys_clk);
    check("fallback", fallback, 32'h1);
    check("irq_fail", irq, 32'h1);
    period(); check("pll_direct", p, PLL_DIV);
    bus(1'b1, omp_pkg::OFF_CLKCFG, 32'h4);
    period(); check("pll_presc", p, 2 * PLL_DIV);
    osc_stop <= 1'b0;
    bus(1'b1, omp_pkg::OFF_CLKCFG, 32'h0);
    bus(1'b1, omp_pkg::OFF_STATUS, 32'h1);
    repeat (50) @(negedge sys_clk);
    check("fb_sticky", fallback, 32'h1);
    bus(1'b0, omp_pkg::OFF_STATE, 32'h0); check("st_fb", q & 32'h6, 32'h6);
    do_reset(1'b1);
    check("fb_reset", fallback, 32'h0);
    bus(1'b0, omp_pkg::OFF_SYSCFG, 32'h0); check("strap_dis", q & 32'h1, 32'h1);
    check("pll_idle", pll_run, 32'h0);
    period(); check("osc_direct", p, 4);
    bus(1'b1, omp_pkg::OFF_MASK, 32'h1);
    osc_stop <= 1'b1;
    repeat (100) @(negedge sys_clk);
    check("dis_irq", irq, 32'h0);
    check("dis_fb", fallback, 32'h0);
    conclude();
  end
endmodule
